/* core/conversion_trigger_pkg.sv */
/*
  Constants shared by the converter control block: register indices, field
  positions, reset values, channel codes and phase lengths.
  Assumes an APB slave with 32-bit data, one register per aligned word.
*/
package conversion_trigger_pkg;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL      = 8'hAD;
  localparam logic [7:0] IDX_TIMING    = 8'hAA;
  localparam logic [7:0] IDX_PIN_LOW   = 8'hAB;
  localparam logic [7:0] IDX_PIN_HIGH  = 8'hAC;
  localparam logic [7:0] IDX_RES_LOW   = 8'hAE;
  localparam logic [7:0] IDX_RES_HIGH  = 8'hAF;
  localparam logic [7:0] IDX_IRQ_STAT  = 8'hB0;
  localparam logic [7:0] IDX_IRQ_MASK  = 8'hB1;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_POWER_BIT   = 7;
  localparam int CTRL_TRIGGER_BIT = 6;
  localparam int CTRL_DONE_BIT    = 5;
  localparam int CTRL_CHAN_MSB    = 4;
  localparam int TIM_LONG_BIT     = 2;
  localparam int TIM_DIV_MSB      = 1;
  localparam int RES_LOW_LSB      = 4;
  localparam int IRQ_DONE_BIT     = 0;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [2:0]  TIMING_RESET   = 3'h0;
  localparam logic [7:0]  PIN_RESET      = 8'h00;
  localparam logic [11:0] RESULT_RESET   = 12'hFFF;

  // ----------------------------------------------------------------------
  // Channel codes
  // ----------------------------------------------------------------------
  localparam logic [4:0] CHAN_PIN_LAST   = 5'h0F;
  localparam logic [4:0] CHAN_QUARTER    = 5'h1F;

  // ----------------------------------------------------------------------
  // Phase lengths in ADC clocks, divider ratios in system clocks
  // ----------------------------------------------------------------------
  localparam logic [5:0] SAMPLE_SHORT = 6'd6;
  localparam logic [5:0] SAMPLE_LONG  = 6'd36;
  localparam logic [5:0] CONVERT_LEN  = 6'd14;
  localparam logic [4:0] DIV_BY16     = 5'd16;
  localparam logic [4:0] DIV_BY12     = 5'd12;
  localparam logic [4:0] DIV_BY6      = 5'd6;
  localparam logic [4:0] DIV_BY4      = 5'd4;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_SAMPLE,
    SEQ_CONVERT
  } conversion_trigger_seq_e;

endpackage

/* core/conversion_trigger_clk_div.sv */
/*
  Divides the system clock into single-cycle ADC clock ticks.
  Assumes the divider code is held steady by the caller during a run.
*/
`timescale 1ns/10ps
module conversion_trigger_clk_div (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [1:0] divSel,
  output logic            adcTick
);

  logic [4:0] ratio;
  logic [4:0] cnt_r;

  // Ratio from the divider code only; sample length never enters here
  always_comb begin
    unique case (divSel)
      2'b00: ratio = conversion_trigger_pkg::DIV_BY16;
      2'b01: ratio = conversion_trigger_pkg::DIV_BY12;
      2'b10: ratio = conversion_trigger_pkg::DIV_BY6;
      2'b11: ratio = conversion_trigger_pkg::DIV_BY4;
    endcase
  end

  // Counter restarts when idle so every run begins phase-aligned
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 5'd0;
    end else if (!run || cnt_r == ratio - 5'd1) begin
      cnt_r <= 5'd0;
    end else begin
      cnt_r <= cnt_r + 5'd1;
    end
  end

  assign adcTick = run && (cnt_r == ratio - 5'd1);

endmodule

/* core/conversion_trigger_pin_ctrl.sv */
/*
  Per-pin handover between digital port use and analog input use.
  Assumes the pad ring honours the analog select and pull-up controls.
*/
`timescale 1ns/10ps
module conversion_trigger_pin_ctrl (
  input  wire logic [15:0] pinEnable,
  input  wire logic [15:0] gpioPullUp,
  output logic [15:0]      padAnalogSel,
  output logic [15:0]      padPullUpEn
);

  // Enabled pins go analog and lose the pull-up; others stay digital
  assign padAnalogSel = pinEnable;
  assign padPullUpEn  = gpioPullUp & ~pinEnable;

endmodule

/* core/conversion_trigger_sequencer.sv */
/*
  Converter control block: APB register file, sample/convert sequencer,
  input mux select, result registers and done interrupt.
  Assumes an analog SAR core that tracks its input while sampleEn is high
  and holds a settled 12-bit value on convResult by the end of conversion.
  Register index is paddr[9:2]; every register sits in the low byte of its
  word and the upper bytes read as zero.
  Assumes gpioPullUp comes from the port logic and that the pad ring obeys
  padAnalogSel and padPullUpEn.
*/
`timescale 1ns/10ps
// How it works
// - Channel code 01111 routes pin 15; codes 10000 to 11110 select nothing.
// - Channel code 11111 routes the quarter-supply monitor.
// - Long sample bit gives 36 ADC clocks of sampling, else 6.
// - Only the divider code sets the ADC clock rate.
// - Sampling is followed by 14 ADC clocks of conversion.
// - Divider code 00 divides by sixteen, code 11 by four.
// - Divider code 01 divides by twelve, code 10 by six.
// - The ADC clock is derived from the system clock.
// - A pin enable bit of 0 leaves the pin as a digital port.
// - A pin enable bit of 1 makes the pin analog and drops its pull-up.
// - Writing 1 to the trigger starts a run and clears done; done sets at end.
// - The channel field is the low five control bits; 00000 is pin 0.
// - Result bits 11..4 go to the high register, 3..0 to the low upper nibble.
module conversion_trigger_sequencer (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic [11:0] convResult,
  input  wire logic [15:0] gpioPullUp,
  output logic             adcPowerEn,
  output logic             sampleEn,
  output logic             convLatch,
  output logic [15:0]      inputPinSel,
  output logic             quarterSupplySel,
  output logic [15:0]      padAnalogSel,
  output logic [15:0]      padPullUpEn,
  output logic             irq
);

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  // Software-visible fields first, then the sequencer's own state
  logic [4:0]  chanSel_r;
  logic        powerEn_r;
  logic        doneFlag_r;
  logic [2:0]  timing_r;
  logic [15:0] pinEnable_r;
  logic [11:0] result_r;
  logic        irqStat_r;
  logic        irqMask_r;
  logic [1:0]  runDiv_r;
  logic        runLong_r;
  logic [5:0]  phaseCnt_r;
  logic        convLatch_r;
  conversion_trigger_pkg::conversion_trigger_seq_e state_r;

  // Bus decode and sequencer helpers
  logic        wrEn;
  logic        rdEn;
  logic [7:0]  regIdx;
  logic        idxHit;
  logic        startReq;
  logic        adcTick;
  logic        runEnd;
  logic [5:0]  sampleLen;
  logic [31:0] rdMux;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  // Zero-wait slave: every access completes in its first access cycle
  // An unmapped index raises pslverr and leaves every register as it was
  // rdEn marks the setup cycle of a read, when read data is loaded
  assign pready  = 1'b1;
  assign wrEn    = psel && penable && pwrite;
  assign rdEn    = psel && !penable && !pwrite;
  assign regIdx  = paddr[9:2];
  assign pslverr = psel && penable && !idxHit;

  // Writing 1 to the trigger bit starts; writing 0 does nothing
  // The trigger is never stored, so a second write of 1 restarts the run
  assign startReq = wrEn && regIdx == conversion_trigger_pkg::IDX_CTRL
                    && pwdata[conversion_trigger_pkg::CTRL_TRIGGER_BIT];

  // Control fields: power and channel select
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chanSel_r <= conversion_trigger_pkg::CTRL_RESET[4:0];
      powerEn_r <= conversion_trigger_pkg::CTRL_RESET[7];
    end else if (wrEn && regIdx == conversion_trigger_pkg::IDX_CTRL) begin
      chanSel_r <= pwdata[conversion_trigger_pkg::CTRL_CHAN_MSB:0];
      powerEn_r <= pwdata[conversion_trigger_pkg::CTRL_POWER_BIT];
    end
  end

  // Done flag: start clears it, completion sets it, software may clear it;
  // completion wins over a same-cycle software clear
  // A control write with the done bit at 1 and the trigger at 0 leaves the flag alone
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      doneFlag_r <= 1'b0;
    end else if (runEnd) begin
      doneFlag_r <= 1'b1;
    end else if (startReq) begin
      doneFlag_r <= 1'b0;
    end else if (wrEn && regIdx == conversion_trigger_pkg::IDX_CTRL
                 && !pwdata[conversion_trigger_pkg::CTRL_DONE_BIT]) begin
      doneFlag_r <= 1'b0;
    end
  end

  // Timing and pin enable registers
  // Pin enables reset to zero so every pin comes up as a digital port
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timing_r    <= conversion_trigger_pkg::TIMING_RESET;
      pinEnable_r <= {conversion_trigger_pkg::PIN_RESET, conversion_trigger_pkg::PIN_RESET};
    end else if (wrEn) begin
      if (regIdx == conversion_trigger_pkg::IDX_TIMING) begin
        timing_r <= pwdata[conversion_trigger_pkg::TIM_LONG_BIT:0];
      end
      if (regIdx == conversion_trigger_pkg::IDX_PIN_LOW) begin
        pinEnable_r[7:0] <= pwdata[7:0];
      end
      if (regIdx == conversion_trigger_pkg::IDX_PIN_HIGH) begin
        pinEnable_r[15:8] <= pwdata[7:0];
      end
    end
  end

  // Interrupt status (write one to clear, set wins) and mask
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irqStat_r <= 1'b0;
      irqMask_r <= 1'b0;
    end else begin
      if (runEnd) begin
        irqStat_r <= 1'b1;
      end else if (wrEn && regIdx == conversion_trigger_pkg::IDX_IRQ_STAT
                   && pwdata[conversion_trigger_pkg::IRQ_DONE_BIT]) begin
        irqStat_r <= 1'b0;
      end
      if (wrEn && regIdx == conversion_trigger_pkg::IDX_IRQ_MASK) begin
        irqMask_r <= pwdata[conversion_trigger_pkg::IRQ_DONE_BIT];
      end
    end
  end

  // Level interrupt: stays high until software clears status or masks it
  assign irq = irqStat_r && irqMask_r;

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // Settings are frozen at start so mid-run writes cannot bend timing
  // Trade-off: a new divider code only takes effect at the next start
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      runDiv_r  <= 2'b00;
      runLong_r <= 1'b0;
    end else if (startReq) begin
      runDiv_r  <= timing_r[conversion_trigger_pkg::TIM_DIV_MSB:0];
      runLong_r <= timing_r[conversion_trigger_pkg::TIM_LONG_BIT];
    end
  end

  // Phase lengths come from the latched copy, never from timing_r
  assign sampleLen = runLong_r ? conversion_trigger_pkg::SAMPLE_LONG : conversion_trigger_pkg::SAMPLE_SHORT;
  assign runEnd    = state_r == conversion_trigger_pkg::SEQ_CONVERT && adcTick
                     && phaseCnt_r == conversion_trigger_pkg::CONVERT_LEN - 6'd1 && !startReq;

  // Phase state and ADC clock counter; a new start always wins
  // phaseCnt_r counts ADC ticks within the current phase and is cleared on
  // every phase change, so one counter serves both phases
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r    <= conversion_trigger_pkg::SEQ_IDLE;
      phaseCnt_r <= 6'd0;
    end else if (startReq) begin
      state_r    <= conversion_trigger_pkg::SEQ_SAMPLE;
      phaseCnt_r <= 6'd0;
    end else if (adcTick) begin
      unique case (state_r)
        conversion_trigger_pkg::SEQ_SAMPLE: begin
          if (phaseCnt_r == sampleLen - 6'd1) begin
            state_r    <= conversion_trigger_pkg::SEQ_CONVERT;
            phaseCnt_r <= 6'd0;
          end else begin
            phaseCnt_r <= phaseCnt_r + 6'd1;
          end
        end
        conversion_trigger_pkg::SEQ_CONVERT: begin
          if (phaseCnt_r == conversion_trigger_pkg::CONVERT_LEN - 6'd1) begin
            state_r    <= conversion_trigger_pkg::SEQ_IDLE;
            phaseCnt_r <= 6'd0;
          end else begin
            phaseCnt_r <= phaseCnt_r + 6'd1;
          end
        end
        conversion_trigger_pkg::SEQ_IDLE: begin
          phaseCnt_r <= 6'd0;
        end
        default: begin
          state_r <= conversion_trigger_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // Divider runs only while a run is active; the start cycle itself is held
  // idle so the first tick always comes a full ratio after the start edge
  conversion_trigger_clk_div u_clk_div (
    .ref_clk (ref_clk),
    .rst     (rst),
    .run     (state_r != conversion_trigger_pkg::SEQ_IDLE && !startReq),
    .divSel  (runDiv_r),
    .adcTick (adcTick)
  );

  // Result capture at end of conversion
  // convLatch is registered on the same edge as the capture, so the result register
  // already holds the new value when the core sees the pulse
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      result_r    <= conversion_trigger_pkg::RESULT_RESET;
      convLatch_r <= 1'b0;
    end else begin
      convLatch_r <= runEnd;
      if (runEnd) begin
        result_r <= convResult;
      end
    end
  end

  // Core-facing levels come straight from registered state
  assign convLatch  = convLatch_r;
  assign sampleEn   = state_r == conversion_trigger_pkg::SEQ_SAMPLE;
  assign adcPowerEn = powerEn_r;

  // ----------------------------------------------------------------------
  // Input select and pins
  // ----------------------------------------------------------------------
  // Reserved codes drive no select line at all
  // Selects follow the channel register at once, not only during a run,
  // so the mux settles before software starts the next conversion
  always_comb begin
    inputPinSel      = 16'h0000;
    quarterSupplySel = 1'b0;
    if (chanSel_r <= conversion_trigger_pkg::CHAN_PIN_LAST) begin
      inputPinSel[chanSel_r[3:0]] = 1'b1;
    end else if (chanSel_r == conversion_trigger_pkg::CHAN_QUARTER) begin
      quarterSupplySel = 1'b1;
    end
  end

  // Pad handover for the sixteen analog-capable pins
  conversion_trigger_pin_ctrl u_pin_ctrl (
    .pinEnable    (pinEnable_r),
    .gpioPullUp   (gpioPullUp),
    .padAnalogSel (padAnalogSel),
    .padPullUpEn  (padPullUpEn)
  );

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  // Trigger reads as zero; it is a strobe, not storage
  // Unmapped indices read as zero and flag the error on pslverr
  always_comb begin
    rdMux  = 32'h0000_0000;
    idxHit = 1'b1;
    unique case (regIdx)
      conversion_trigger_pkg::IDX_CTRL:     rdMux[7:0] = {powerEn_r, 1'b0, doneFlag_r, chanSel_r};
      conversion_trigger_pkg::IDX_TIMING:   rdMux[2:0] = timing_r;
      conversion_trigger_pkg::IDX_PIN_LOW:  rdMux[7:0] = pinEnable_r[7:0];
      conversion_trigger_pkg::IDX_PIN_HIGH: rdMux[7:0] = pinEnable_r[15:8];
      conversion_trigger_pkg::IDX_RES_LOW:  rdMux[7:0] = {result_r[3:0], 4'h0};
      conversion_trigger_pkg::IDX_RES_HIGH: rdMux[7:0] = result_r[11:4];
      conversion_trigger_pkg::IDX_IRQ_STAT: rdMux[0]   = irqStat_r;
      conversion_trigger_pkg::IDX_IRQ_MASK: rdMux[0]   = irqMask_r;
      default:                idxHit     = 1'b0;
    endcase
  end

  // Read data registered on the access edge's setup, held otherwise
  // Loading in the setup cycle keeps prdata steady through the access phase
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (rdEn) begin
      prdata <= rdMux;
    end
  end

endmodule

/* verif/conversion_trigger_sequencer_asserts.sv */
/*
  Port checker for the converter control block.
  Assumes one clock domain and the asynchronous active-high reset.
*/
`timescale 1ns/10ps
module conversion_trigger_sequencer_asserts (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [15:0] gpioPullUp,
  input wire logic        sampleEn,
  input wire logic        convLatch,
  input wire logic [15:0] inputPinSel,
  input wire logic        quarterSupplySel,
  input wire logic [15:0] padAnalogSel,
  input wire logic [15:0] padPullUpEn
);
  logic [7:0] idx;
  logic       wr;
  logic       start;
  logic [2:0] tim_r;
  logic [2:0] run_r;
  int         samp_r;
  int         conv_r;
  int         divV;
  int         expS;
  int         expC;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Settings a run latched at start give the expected phase lengths
  assign idx   = paddr[9:2];
  assign wr    = psel && penable && pwrite;
  assign start = wr && idx == conversion_trigger_pkg::IDX_CTRL && pwdata[6];
  assign divV  = run_r[1] ? (run_r[0] ? 4 : 6) : (run_r[0] ? 12 : 16);
  assign expS  = (run_r[2] ? 36 : 6) * divV;
  assign expC  = 14 * divV;

  // Phase counters restart on every trigger, so a restart is measured whole
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tim_r  <= 3'h0;
      run_r  <= 3'h0;
      samp_r <= 0;
      conv_r <= 0;
    end else begin
      if (wr && idx == conversion_trigger_pkg::IDX_TIMING) tim_r <= pwdata[2:0];
      if (start) run_r <= tim_r;
      samp_r <= start ? 0 : samp_r + 32'(sampleEn);
      conv_r <= (start || sampleEn) ? 0 : conv_r + 1;
    end
  end

  a_chan_route: assert property (
    wr && idx == conversion_trigger_pkg::IDX_CTRL |=> inputPinSel ==
    ($past(pwdata[4]) ? 16'h0000 : 16'h0001 << $past(pwdata[3:0])))
    else $error("pin select does not follow channel code");
  a_quarter_sel: assert property (
    wr && idx == conversion_trigger_pkg::IDX_CTRL |=> quarterSupplySel == ($past(pwdata[4:0]) == 5'h1F))
    else $error("quarter supply select wrong");
  a_pin_low: assert property (
    wr && idx == conversion_trigger_pkg::IDX_PIN_LOW |=> padAnalogSel[7:0] == $past(pwdata[7:0]))
    else $error("analog select not taken from pin enables");
  a_pull_handover: assert property (
    padPullUpEn == (gpioPullUp & ~padAnalogSel))
    else $error("pull-up kept on an analog pin");
  a_start_samples: assert property (
    start |=> sampleEn && !convLatch)
    else $error("trigger did not begin sampling");
  a_sample_len: assert property (
    $fell(sampleEn) |-> samp_r >= expS && samp_r <= expS + 1)
    else $error("sampling length wrong");
  a_convert_len: assert property (
    $rose(convLatch) |-> conv_r >= expC && conv_r <= expC + 2)
    else $error("conversion length wrong");
  a_latch_pulse: assert property (
    $rose(convLatch) |=> !convLatch && (!sampleEn || $past(start)))
    else $error("result pulse longer than one cycle");

  c_start: cover property (start);
  c_done: cover property ($rose(convLatch));
  c_midrun: cover property (wr && idx == conversion_trigger_pkg::IDX_TIMING && sampleEn);
endmodule

bind conversion_trigger_sequencer conversion_trigger_sequencer_asserts u_conversion_trigger_sequencer_asserts (
  .ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .gpioPullUp,
  .sampleEn, .convLatch, .inputPinSel, .quarterSupplySel, .padAnalogSel,
  .padPullUpEn
);

/* verif/conversion_trigger_sar_model.sv */
/*
  Behavioural sample-and-convert core on the far side of the block.
  Assumes the one-hot pin select and the quarter-supply select.
*/
`timescale 1ns/10ps
module conversion_trigger_sar_model (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        sampleEn,
  input  wire logic        convLatch,
  input  wire logic [15:0] inputPinSel,
  input  wire logic        quarterSupplySel,
  output logic [11:0]      convResult
);
  logic [4:0]  code;
  logic [11:0] held_r;
  logic        busy_r;

  // Code of the routed input; no select reads as a code of its own
  always_comb begin
    code = quarterSupplySel ? 5'h1F : 5'h10;
    for (int k = 0; k < 16; k++) begin
      if (inputPinSel[k]) code = 5'(k);
    end
  end

  // Track while sampling, hold once sampling stops
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      held_r <= 12'h000;
      busy_r <= 1'h0;
    end else if (sampleEn) begin
      held_r <= {7'h5A, code};
      busy_r <= 1'h1;
    end else if (convLatch) begin
      busy_r <= 1'h0;
    end
  end

  // Outside a conversion show the inverse, so a stale value cannot pass
  assign convResult = (busy_r && !sampleEn) ? held_r : ~held_r;
endmodule

/* verif/tb_top.sv */
/*
  Self-checking bench for the converter control block.
  Assumes the core model beside it and APB access from the tasks here.
*/
`timescale 1ns/10ps
module tb_top;
  logic        ref_clk, rst, psel, penable, pwrite, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic        pready, pslverr, adcPowerEn, sampleEn, convLatch, quarterSupplySel, irq;
  logic [11:0] convResult, res;
  logic [15:0] gpioPullUp, inputPinSel, padAnalogSel, padPullUpEn;
  logic [4:0]  ch;
  int          failCount, comparisons, cyc, t0, d;
  int          dv[4] = '{16, 12, 6, 4};

  conversion_trigger_sequencer u_conversion_trigger_sequencer (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .pslverr, .prdata, .convResult, .gpioPullUp, .adcPowerEn,
    .sampleEn, .convLatch, .inputPinSel, .quarterSupplySel, .padAnalogSel,
    .padPullUpEn, .irq);
  conversion_trigger_sar_model u_conversion_trigger_sar_model (.ref_clk, .rst, .sampleEn, .convLatch,
    .inputPinSel, .quarterSupplySel, .convResult);

  // ------------------------------------------------------------
  // Clock, cycle count, watchdog
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc <= cyc + 1;
  // Runs need about 3100 cycles; 20000 leaves room
  initial begin
    #1000000;
    failCount++;
    closeOut();
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  // One APB transfer; held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge ref_clk);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= {22'h0, idx, 2'h0};
    pwdata  <= wd;
    @(posedge ref_clk);
    penable <= 1'h1;
    @(posedge ref_clk);
    while (pready !== 1'h1) @(posedge ref_clk);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failCount++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Phase lengths carry a cycle or two of pipeline slack
  task automatic chkNear(input int got, input int exp, input int slack);
    chk(32'((got >= exp && got <= exp + slack) ? exp : got), 32'(exp));
  endtask
  task automatic measure(input int ts, input int es, input int ec);
    int t1;
    @(negedge ref_clk);
    while (sampleEn === 1'h1) @(negedge ref_clk);
    t1 = cyc;
    chkNear(t1 - ts, es, 1);
    while (convLatch !== 1'h1) @(negedge ref_clk);
    chkNear(cyc - t1, ec, 2);
  endtask
  task automatic closeOut();
    if (failCount == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    {psel, penable, pwrite} = 3'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    gpioPullUp = 16'hF0F0;
    rst = 1'h1;
    repeat (8) @(posedge ref_clk);
    rst <= 1'h0;
    apb(0, conversion_trigger_pkg::IDX_PIN_LOW, 0); chk(rd, 32'h0);
    apb(0, conversion_trigger_pkg::IDX_RES_HIGH, 0); chk(rd, 32'hFF);
    apb(0, conversion_trigger_pkg::IDX_RES_LOW, 0); chk(rd & 32'hF0, 32'hF0);
    apb(0, conversion_trigger_pkg::IDX_TIMING, 0); chk(rd & 32'h7, 32'h0);
    chk(32'(padPullUpEn), 32'hF0F0);
    chk(32'(adcPowerEn), 32'h0);
    // Unmapped place refuses both directions
    apb(1, 8'h10, 32'hFF); chk(32'(err), 32'h1);
    apb(0, 8'h10, 0); chk(rd, 32'h0);
    apb(1, conversion_trigger_pkg::IDX_PIN_LOW, 32'hA5);
    apb(1, conversion_trigger_pkg::IDX_PIN_HIGH, 32'h3C);
    apb(0, conversion_trigger_pkg::IDX_PIN_HIGH, 0); chk(rd, 32'h3C);
    chk(32'(padPullUpEn), 32'(16'hF0F0 & ~16'h3CA5));
    chk(32'(padAnalogSel), 32'h3CA5);
    gpioPullUp <= 16'hFFFF;
    @(negedge ref_clk);
    chk(32'(padPullUpEn), 32'hC35A);
    // Every channel code, reserved ones included
    for (int c = 0; c < 32; c++) begin
      apb(1, conversion_trigger_pkg::IDX_CTRL, 32'h80 | c);
      @(negedge ref_clk);
      chk(32'(inputPinSel), c < 16 ? 32'h1 << c : 32'h0);
      chk(32'(quarterSupplySel), 32'(c == 31));
    end
    chk(32'(adcPowerEn), 32'h1);
    // Every divider code with both sample lengths; odd runs unmask the irq
    for (int i = 0; i < 8; i++) begin
      ch = (i == 7) ? 5'h1F : 5'(2 * i + 3);
      res = {7'h5A, ch};
      d = dv[i % 4];
      apb(1, conversion_trigger_pkg::IDX_IRQ_MASK, 32'(i % 2));
      apb(1, conversion_trigger_pkg::IDX_TIMING, 32'(i));
      apb(1, conversion_trigger_pkg::IDX_CTRL, 32'hC0 | 32'(ch));
      measure(cyc, (i < 4 ? 6 : 36) * d + 1, 14 * d);
      apb(0, conversion_trigger_pkg::IDX_CTRL, 0); chk(rd & 32'hE0, 32'hA0);
      apb(0, conversion_trigger_pkg::IDX_RES_HIGH, 0); chk(rd, 32'(res[11:4]));
      apb(0, conversion_trigger_pkg::IDX_RES_LOW, 0); chk(rd & 32'hF0, 32'({res[3:0], 4'h0}));
      chk(32'(irq), 32'(i % 2));
      apb(0, conversion_trigger_pkg::IDX_IRQ_STAT, 0); chk(rd, 32'h1);
      apb(1, conversion_trigger_pkg::IDX_IRQ_STAT, 32'h1);
      @(negedge ref_clk);
      chk(32'(irq), 32'h0);
    end
    // Restart mid-sampling, then change timing while the run goes on
    apb(1, conversion_trigger_pkg::IDX_TIMING, 32'h3);
    apb(1, conversion_trigger_pkg::IDX_CTRL, 32'hE0);
    apb(0, conversion_trigger_pkg::IDX_CTRL, 0); chk(rd & 32'h20, 32'h0);
    apb(1, conversion_trigger_pkg::IDX_CTRL, 32'hC0);
    t0 = cyc;
    apb(1, conversion_trigger_pkg::IDX_TIMING, 32'h4);
    measure(t0, 25, 56);
    apb(1, conversion_trigger_pkg::IDX_CTRL, 32'hA0);
    @(negedge ref_clk);
    chk(32'(sampleEn), 32'h0);
    apb(0, conversion_trigger_pkg::IDX_CTRL, 0); chk(rd & 32'hE0, 32'hA0);
    closeOut();
  end
endmodule
